// ==== dv/ppf_chk_sva.sv ====
// Checker bound onto ppf_top: pin ownership, pull-ups, test output.
// Assumes one clock domain and ports named as in ppf_top.
`timescale 1ns/1ps
module ppf_chk (
  input logic core_clk_i, arst_n_i, cfg_we_i, bus_drive_ctrl_bit_i, ext_bus_active_i,
  input logic test_pullup_disable_i, test_shift_state_i, test_tdo_i,
  input logic [7:0] port_d_dir_i, port_d_periph_enable_i, port_d_pullup_i, port_d_pad_i,
  input logic [5:0] chip_select_n_i,
  input logic [1:0] port_e_pullup_i, port_e_pad_i, port_e_pull_en_o, port_e_din_o,
  input logic [7:0] port_d_pad_o, port_d_pad_oe_o, port_d_pull_en_o, port_d_din_o,
  input logic test_pull_en_o, test_tdo_o, test_tdo_oe_o, serial0_rx_o, serial1_rx_o
);
  logic [1:0] up_reg;
  wire live = up_reg == 2'h3;
  // Edges since release, so that $past never looks back into reset
  always_ff @(posedge core_clk_i or negedge arst_n_i)
    if (!arst_n_i) up_reg <= 2'h0;
    else if (!live) up_reg <= up_reg + 2'h1;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  a_rst_pins: assert property (disable iff (1'b0)
    !arst_n_i |-> port_d_pad_oe_o == 8'h00 && port_d_pull_en_o == 8'hff && test_pull_en_o
    && !test_tdo_oe_o) else $error("reset pin state");
  a_tdo_window: assert property (live |-> test_tdo_oe_o == $past(test_shift_state_i))
    else $error("tdo enable");
  a_tdo_data: assert property (live && test_tdo_oe_o |-> test_tdo_o == $past(test_tdo_i))
    else $error("tdo data");
  a_pad_input: assert property (live |-> {port_d_din_o, port_e_din_o, serial1_rx_o,
    serial0_rx_o} == $past({port_d_pad_i, port_e_pad_i, port_d_pad_i[7], port_e_pad_i[1]}))
    else $error("pad input");
  a_pd_pullup: assert property (live && $past(cfg_we_i, 2) |->
    port_d_pull_en_o == ($past(port_d_pullup_i, 2) ^ 8'h40)) else $error("port d pull");
  a_pe_pullup: assert property (live && $past(cfg_we_i, 2) |->
    port_e_pull_en_o == $past(port_e_pullup_i, 2)) else $error("port e pull");
  a_test_pullup: assert property (live && $past(cfg_we_i, 2) |->
    test_pull_en_o == !$past(test_pullup_disable_i, 2)) else $error("test pull");
  a_gpio_dir: assert property (live && $past(cfg_we_i, 2) &&
    $past(port_d_periph_enable_i, 2) == 8'h00 |-> port_d_pad_oe_o == $past(port_d_dir_i, 2))
    else $error("port d dir");
  a_cs_drive: assert property (live && $past(cfg_we_i, 2) &&
    $past(port_d_periph_enable_i, 2) == 8'h3f |-> port_d_pad_o[5:0] == $past(chip_select_n_i)
    && port_d_pad_oe_o[5:0] == {6{$past(bus_drive_ctrl_bit_i, 2) | $past(ext_bus_active_i)}})
    else $error("chip select");
  c_cs_float: cover property (live && port_d_pad_oe_o[5:0] == 6'h00 && $past(cfg_we_i, 2));
  c_tdo_on: cover property (test_tdo_oe_o);
  c_test_pu_off: cover property (!test_pull_en_o);
endmodule // ppf_chk
bind ppf_top ppf_chk ppf_chk_inst (.*);

// ==== dv/tb_ppf_top.sv ====
// Self-checking bench for ppf_top: corner and random pin configurations.
// Assumes ppf_top and its bound checker are compiled first.
`timescale 1ns/1ps
module tb_ppf_top;
  logic core_clk_i, arst_n_i, cfg_we_i, bus_drive_ctrl_bit_i, test_pullup_disable_i;
  logic ext_bus_active_i, serial0_tx_i, serial1_tx_i, test_shift_state_i, test_tdo_i;
  logic [7:0] port_d_dir_i, port_d_dout_i, port_d_periph_enable_i, port_d_pullup_i, port_d_pad_i;
  logic [1:0] port_e_dir_i, port_e_dout_i, port_e_periph_enable_i, port_e_pullup_i, port_e_pad_i;
  logic [5:0] chip_select_n_i;
  logic [7:0] port_d_pad_o, port_d_pad_oe_o, port_d_pull_en_o, port_d_din_o;
  logic [1:0] port_e_pad_o, port_e_pad_oe_o, port_e_pull_en_o, port_e_din_o;
  logic test_pull_en_o, test_tdo_o, test_tdo_oe_o, serial0_rx_o, serial1_rx_o;
  int fail_count = 0;
  int check_count = 0;
  ppf_top ppf_top_inst (.*);
  // Free-running clock
  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // Expected port D enables and data; the serial receive pin is never driven while serial 1 owns it
  function automatic logic [7:0] d_oe();
    for (int b = 0; b < 8; b++)
      d_oe[b] = !port_d_periph_enable_i[b] ? port_d_dir_i[b] :
        b < 6 ? bus_drive_ctrl_bit_i | ext_bus_active_i : b == 6;
  endfunction
  function automatic logic [7:0] d_do();
    for (int b = 0; b < 8; b++)
      d_do[b] = !port_d_periph_enable_i[b] ? port_d_dout_i[b] :
        b < 6 ? chip_select_n_i[b] : serial1_tx_i;
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Pad data only matters where the pad is driven
  task automatic check_all();
    logic [7:0] m;
    logic [1:0] pe;
    logic [1:0] eo;
    logic [1:0] ed;
    m = d_oe();
    pe = port_e_periph_enable_i;
    eo = (pe & 2'h1) | (~pe & port_e_dir_i);
    ed = (pe & {1'b0, serial0_tx_i}) | (~pe & port_e_dout_i);
    check("pd_oe", port_d_pad_oe_o, m);
    check("pd_do", port_d_pad_o & m, d_do() & m);
    check("pe_oe", port_e_pad_oe_o, (pe & 2'h1) | (~pe & port_e_dir_i));
    check("pe_do", port_e_pad_o[0], pe[0] ? serial0_tx_i : port_e_dout_i[0]);
    check("pd_pu", port_d_pull_en_o, port_d_pullup_i ^ 8'h40);
    check("pe_pu", port_e_pull_en_o, port_e_pullup_i);
    check("t_pu", test_pull_en_o, !test_pullup_disable_i);
    check("pe_do1", port_e_pad_o[1] & eo[1], ed[1] & eo[1]);
    check("din", {port_d_din_o, port_e_din_o}, {port_d_pad_i, port_e_pad_i});
    check("rx", {serial1_rx_o, serial0_rx_o}, {port_d_pad_i[7], port_e_pad_i[1]});
    check("tdo_oe", test_tdo_oe_o, test_shift_state_i);
    check("tdo", test_tdo_o & test_tdo_oe_o, test_tdo_i & test_shift_state_i);
  endtask
  // One config write with fresh live inputs, held until outputs settle
  task automatic drive(input logic [7:0] per, input logic drv, act);
    @(negedge core_clk_i);
    {port_d_dir_i, port_d_dout_i, port_d_pullup_i, port_d_pad_i} = $urandom;
    {port_e_dir_i, port_e_dout_i, port_e_periph_enable_i, port_e_pullup_i} = $urandom;
    {chip_select_n_i, serial0_tx_i, serial1_tx_i, test_shift_state_i, test_tdo_i} = $urandom;
    {port_e_pad_i, test_pullup_disable_i} = $urandom;
    port_d_periph_enable_i = per;
    bus_drive_ctrl_bit_i = drv;
    ext_bus_active_i = act;
    cfg_we_i = 1'b1;
    @(negedge core_clk_i);
    cfg_we_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Reset, defaults, chip-select corners, then random configurations
  initial
  begin
    {arst_n_i, cfg_we_i, bus_drive_ctrl_bit_i, test_pullup_disable_i, ext_bus_active_i} = 5'h10;
    {serial0_tx_i, serial1_tx_i, test_shift_state_i, test_tdo_i, chip_select_n_i} = 10'h0;
    {port_d_dir_i, port_d_dout_i, port_d_pad_i, port_e_dir_i, port_e_dout_i, port_e_pad_i} = 30'h0;
    {port_d_periph_enable_i, port_d_pullup_i, port_e_periph_enable_i, port_e_pullup_i} = 20'hc0fff;
    void'($urandom(32'hde381f5d));
    // A clean falling edge after time zero, so the reset cannot be missed at start-up
    #1 arst_n_i = 1'b0;
    repeat (10) @(negedge core_clk_i);
    check("rst", {port_d_pad_oe_o, port_d_pull_en_o, test_pull_en_o}, 17'h1ff);
    repeat (2) @(negedge core_clk_i);
    arst_n_i = 1'b1;
    repeat (3) @(negedge core_clk_i);
    check_all();
    for (int i = 0; i < 40; i++)
    begin
      if (i < 4) drive(8'h3f, i[0], i[1]);
      else if (i < 6) drive(8'h00, i[0], i[1]);
      else drive($urandom, $urandom, $urandom);
      check_all();
    end
    print_verdict();
  end
  // Watchdog well beyond the roughly 175 cycles the run needs
  initial
  begin
    #20us;
    fail_count++;
    print_verdict();
  end
endmodule // tb_ppf_top

// ==== logic/ppf_consts.vh ====
// Constants for the port pin function and pull-up control block.
// Assumes inclusion by bare name from files under logic/.
`ifndef PPF_CONSTS_VH
`define PPF_CONSTS_VH
`define PPF_PD_W 8
`define PPF_PE_W 2
`define PPF_PD_CS_W 6
`define PPF_PD_TX1 6
`define PPF_PD_RX1 7
`define PPF_PE_TX0 0
`define PPF_PE_RX0 1
`define PPF_PD_PER_RST 8'hc0
`define PPF_PE_PER_RST 2'h3
`define PPF_PD_PU_RST 8'hff
`define PPF_PE_PU_RST 2'h3
`define PPF_PD_PU_INV 8'h40
`define PPF_PE_PU_INV 2'h0
`define PPF_PULL_RST 1'b1
`define PPF_RX_RST 1'b1
`define PPF_PD_DIR_RST 8'h00
`define PPF_PE_DIR_RST 2'h0
`endif

// ==== logic/ppf_pad_sel.v ====
// Per-pad owner selection between port logic and a peripheral.
// Assumes all controls are synchronous to core_clk_i.
`timescale 1ns/1ps
module ppf_pad_sel #(
  parameter W = 8
) (
  input wire [W-1:0] per_en_i,
  input wire [W-1:0] port_oe_i,
  input wire [W-1:0] port_do_i,
  input wire [W-1:0] periph_oe_i,
  input wire [W-1:0] periph_do_i,
  output wire [W-1:0] oe_o,
  output wire [W-1:0] do_o
);
  // Owner mux per bit
  assign oe_o = (per_en_i & periph_oe_i) | (~per_en_i & port_oe_i);
  assign do_o = (per_en_i & periph_do_i) | (~per_en_i & port_do_i);
endmodule // ppf_pad_sel

// ==== logic/ppf_top.v ====
// Top of the port D / port E pin function and pull-up control.
// Assumes every input is synchronous to core_clk_i; pads are resolved outside.
`timescale 1ns/1ps
`include "ppf_consts.vh"
module ppf_top (
  input wire core_clk_i,
  input wire arst_n_i,
  input wire [`PPF_PD_W-1:0] port_d_dir_i,
  input wire [`PPF_PD_W-1:0] port_d_dout_i,
  input wire [`PPF_PD_W-1:0] port_d_periph_enable_i,
  input wire [`PPF_PD_W-1:0] port_d_pullup_i,
  input wire [`PPF_PE_W-1:0] port_e_dir_i,
  input wire [`PPF_PE_W-1:0] port_e_dout_i,
  input wire [`PPF_PE_W-1:0] port_e_periph_enable_i,
  input wire [`PPF_PE_W-1:0] port_e_pullup_i,
  input wire cfg_we_i,
  input wire bus_drive_ctrl_bit_i,
  input wire test_pullup_disable_i,
  input wire [`PPF_PD_CS_W-1:0] chip_select_n_i,
  input wire ext_bus_active_i,
  input wire serial0_tx_i,
  input wire serial1_tx_i,
  input wire test_shift_state_i,
  input wire test_tdo_i,
  input wire [`PPF_PD_W-1:0] port_d_pad_i,
  input wire [`PPF_PE_W-1:0] port_e_pad_i,
  output reg [`PPF_PD_W-1:0] port_d_pad_o,
  output reg [`PPF_PD_W-1:0] port_d_pad_oe_o,
  output reg [`PPF_PD_W-1:0] port_d_pull_en_o,
  output reg [`PPF_PE_W-1:0] port_e_pad_o,
  output reg [`PPF_PE_W-1:0] port_e_pad_oe_o,
  output reg [`PPF_PE_W-1:0] port_e_pull_en_o,
  output reg test_pull_en_o,
  output reg test_tdo_o,
  output reg test_tdo_oe_o,
  output reg [`PPF_PD_W-1:0] port_d_din_o,
  output reg [`PPF_PE_W-1:0] port_e_din_o,
  output reg serial0_rx_o,
  output reg serial1_rx_o
);
  // Configuration registers, loaded on cfg_we_i; the data and reset-flag registers load every cycle
  reg [`PPF_PD_W-1:0] port_d_dir_reg;
  reg [`PPF_PD_W-1:0] port_b_periph_enable_reg;
  reg [`PPF_PD_W-1:0] port_d_pullup_reg;
  reg [`PPF_PE_W-1:0] port_e_dir_reg;
  reg [`PPF_PE_W-1:0] port_e_periph_enable_reg;
  reg [`PPF_PE_W-1:0] port_e_pullup_reg;
  reg bus_drive_ctrl_reg;
  reg system_pullup_disable_reg;
  reg [`PPF_PD_W-1:0] port_d_dout_reg;
  reg [`PPF_PE_W-1:0] port_e_dout_reg;
  reg in_reset_reg;
  wire [`PPF_PD_W-1:0] pd_per_oe;
  wire [`PPF_PD_W-1:0] pd_per_do;
  wire [`PPF_PE_W-1:0] pe_per_oe;
  wire [`PPF_PE_W-1:0] pe_per_do;
  wire [`PPF_PD_W-1:0] pd_oe;
  wire [`PPF_PD_W-1:0] pd_do;
  wire [`PPF_PE_W-1:0] pe_oe;
  wire [`PPF_PE_W-1:0] pe_do;
  wire cs_drive;
  // Next values of the configuration registers
  reg [`PPF_PD_W-1:0] port_d_dir_next;
  reg [`PPF_PD_W-1:0] port_b_periph_enable_next;
  reg [`PPF_PD_W-1:0] port_d_pullup_next;
  reg [`PPF_PE_W-1:0] port_e_dir_next;
  reg [`PPF_PE_W-1:0] port_e_periph_enable_next;
  reg [`PPF_PE_W-1:0] port_e_pullup_next;
  reg bus_drive_ctrl_next;
  reg system_pullup_disable_next;
  // Next values of the registered outputs
  reg [`PPF_PD_W-1:0] port_d_pad_next;
  reg [`PPF_PD_W-1:0] port_d_pad_oe_next;
  reg [`PPF_PD_W-1:0] port_d_pull_en_next;
  reg [`PPF_PE_W-1:0] port_e_pad_next;
  reg [`PPF_PE_W-1:0] port_e_pad_oe_next;
  reg [`PPF_PE_W-1:0] port_e_pull_en_next;
  reg test_pull_en_next;
  reg test_tdo_next;
  reg test_tdo_oe_next;
  reg [`PPF_PD_W-1:0] port_d_din_next;
  reg [`PPF_PE_W-1:0] port_e_din_next;
  reg serial0_rx_next;
  reg serial1_rx_next;
  // Pull-up sense per pin; only port D pin 6 is inverted
  localparam [`PPF_PD_W-1:0] PD_PU_INV = `PPF_PD_PU_INV;
  localparam [`PPF_PE_W-1:0] PE_PU_INV = `PPF_PE_PU_INV;
  // Loop index of the per-pin decode
  integer pin;

  // One pin's pull-up enable; a set sense bit means a set register bit disables it
  function pull_bit;
    input pur_bit;
    input inv_bit;
    begin
      pull_bit = pur_bit ^ inv_bit;
    end
  endfunction

  // One pin's output enable, held off while the pins are still inputs after reset
  function oe_hold;
    input oe_bit;
    input hold;
    begin
      oe_hold = oe_bit & ~hold;
    end
  endfunction

  // Configuration is taken only on the load strobe; otherwise every register holds
  always @*
  begin
    port_d_dir_next = port_d_dir_reg;
    port_b_periph_enable_next = port_b_periph_enable_reg;
    port_d_pullup_next = port_d_pullup_reg;
    port_e_dir_next = port_e_dir_reg;
    port_e_periph_enable_next = port_e_periph_enable_reg;
    port_e_pullup_next = port_e_pullup_reg;
    bus_drive_ctrl_next = bus_drive_ctrl_reg;
    system_pullup_disable_next = system_pullup_disable_reg;
    if (cfg_we_i)
    begin
      port_d_dir_next = port_d_dir_i;
      port_b_periph_enable_next = port_d_periph_enable_i;
      port_d_pullup_next = port_d_pullup_i;
      port_e_dir_next = port_e_dir_i;
      port_e_periph_enable_next = port_e_periph_enable_i;
      port_e_pullup_next = port_e_pullup_i;
      bus_drive_ctrl_next = bus_drive_ctrl_bit_i;
      system_pullup_disable_next = test_pullup_disable_i;
    end
  end

  // Configuration flops; port_b_periph_enable_reg holds the port D peripheral enables
  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      port_d_dir_reg <= `PPF_PD_DIR_RST;
      port_b_periph_enable_reg <= `PPF_PD_PER_RST;
      port_d_pullup_reg <= `PPF_PD_PU_RST;
      port_e_dir_reg <= `PPF_PE_DIR_RST;
      port_e_periph_enable_reg <= `PPF_PE_PER_RST;
      port_e_pullup_reg <= `PPF_PE_PU_RST;
      bus_drive_ctrl_reg <= 1'b0;
      system_pullup_disable_reg <= 1'b0;
    end
    else
    begin
      port_d_dir_reg <= port_d_dir_next;
      port_b_periph_enable_reg <= port_b_periph_enable_next;
      port_d_pullup_reg <= port_d_pullup_next;
      port_e_dir_reg <= port_e_dir_next;
      port_e_periph_enable_reg <= port_e_periph_enable_next;
      port_e_pullup_reg <= port_e_pullup_next;
      bus_drive_ctrl_reg <= bus_drive_ctrl_next;
      system_pullup_disable_reg <= system_pullup_disable_next;
    end
  end

  // Port output data is registered every cycle; the flag marks the first edge after release
  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      port_d_dout_reg <= {`PPF_PD_W{1'b0}};
      port_e_dout_reg <= {`PPF_PE_W{1'b0}};
      in_reset_reg <= 1'b1;
    end
    else
    begin
      port_d_dout_reg <= port_d_dout_i;
      port_e_dout_reg <= port_e_dout_i;
      in_reset_reg <= 1'b0;
    end
  end

  // Chip selects float when idle only if the drive control bit is clear
  assign cs_drive = bus_drive_ctrl_reg | ext_bus_active_i;
  // Peripheral side of port D: chip selects on 0..5, serial 1 on 6 and 7
  assign pd_per_oe = {1'b0, 1'b1, {`PPF_PD_CS_W{cs_drive}}};
  assign pd_per_do = {1'b0, serial1_tx_i, chip_select_n_i};
  // Peripheral side of port E: serial 0 transmit on 0, receive on 1
  assign pe_per_oe = {1'b0, 1'b1};
  assign pe_per_do = {1'b0, serial0_tx_i};

  ppf_pad_sel #(
    .W(`PPF_PD_W)
  ) u_pd_sel (
    .per_en_i(port_b_periph_enable_reg),
    .port_oe_i(port_d_dir_reg),
    .port_do_i(port_d_dout_reg),
    .periph_oe_i(pd_per_oe),
    .periph_do_i(pd_per_do),
    .oe_o(pd_oe),
    .do_o(pd_do)
  );

  ppf_pad_sel #(
    .W(`PPF_PE_W)
  ) u_pe_sel (
    .per_en_i(port_e_periph_enable_reg),
    .port_oe_i(port_e_dir_reg),
    .port_do_i(port_e_dout_reg),
    .periph_oe_i(pe_per_oe),
    .periph_do_i(pe_per_do),
    .oe_o(pe_oe),
    .do_o(pe_do)
  );

  // Per-pin decode of pad enables and pull-ups for both ports
  always @*
  begin
    port_d_pad_oe_next = {`PPF_PD_W{1'b0}};
    port_d_pull_en_next = {`PPF_PD_W{1'b0}};
    port_e_pad_oe_next = {`PPF_PE_W{1'b0}};
    port_e_pull_en_next = {`PPF_PE_W{1'b0}};
    for (pin = 0; pin < `PPF_PD_W; pin = pin + 1)
    begin
      port_d_pad_oe_next[pin] = oe_hold(pd_oe[pin], in_reset_reg);
      port_d_pull_en_next[pin] = pull_bit(port_d_pullup_reg[pin], PD_PU_INV[pin]);
    end
    for (pin = 0; pin < `PPF_PE_W; pin = pin + 1)
    begin
      port_e_pad_oe_next[pin] = oe_hold(pe_oe[pin], in_reset_reg);
      port_e_pull_en_next[pin] = pull_bit(port_e_pullup_reg[pin], PE_PU_INV[pin]);
    end
  end

  // Pad data, test port and input routing need no per-pin decode
  always @*
  begin
    port_d_pad_next = pd_do;
    port_e_pad_next = pe_do;
    test_pull_en_next = ~system_pullup_disable_reg;
    test_tdo_next = test_tdo_i;
    test_tdo_oe_next = test_shift_state_i;
    // Input data reaches both owners regardless of selection
    port_d_din_next = port_d_pad_i;
    port_e_din_next = port_e_pad_i;
    serial0_rx_next = port_e_pad_i[`PPF_PE_RX0];
    serial1_rx_next = port_d_pad_i[`PPF_PD_RX1];
  end

  // Pad drive flops; enables stay off while reset holds the pins as inputs
  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      port_d_pad_o <= {`PPF_PD_W{1'b0}};
      port_d_pad_oe_o <= {`PPF_PD_W{1'b0}};
      port_e_pad_o <= {`PPF_PE_W{1'b0}};
      port_e_pad_oe_o <= {`PPF_PE_W{1'b0}};
    end
    else
    begin
      port_d_pad_o <= port_d_pad_next;
      port_d_pad_oe_o <= port_d_pad_oe_next;
      port_e_pad_o <= port_e_pad_next;
      port_e_pad_oe_o <= port_e_pad_oe_next;
    end
  end

  // Pull-up flops; every pull-up is on during reset so undriven inputs read high
  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      port_d_pull_en_o <= {`PPF_PD_W{`PPF_PULL_RST}};
      port_e_pull_en_o <= {`PPF_PE_W{`PPF_PULL_RST}};
      test_pull_en_o <= `PPF_PULL_RST;
    end
    else
    begin
      port_d_pull_en_o <= port_d_pull_en_next;
      port_e_pull_en_o <= port_e_pull_en_next;
      test_pull_en_o <= test_pull_en_next;
    end
  end

  // Test data output flops; the enable follows the shift states one cycle late
  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      test_tdo_o <= 1'b0;
      test_tdo_oe_o <= 1'b0;
    end
    else
    begin
      test_tdo_o <= test_tdo_next;
      test_tdo_oe_o <= test_tdo_oe_next;
    end
  end

  // Input routing flops; serial receive lines idle high during reset
  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      port_d_din_o <= {`PPF_PD_W{1'b0}};
      port_e_din_o <= {`PPF_PE_W{1'b0}};
      serial0_rx_o <= `PPF_RX_RST;
      serial1_rx_o <= `PPF_RX_RST;
    end
    else
    begin
      port_d_din_o <= port_d_din_next;
      port_e_din_o <= port_e_din_next;
      serial0_rx_o <= serial0_rx_next;
      serial1_rx_o <= serial1_rx_next;
    end
  end
endmodule // ppf_top
